// ---- bench/clock_sources.sv ----
// four reference clock sources, period set in 8 ns clk cycles
// zero stops a source low; offsets keep edges off the clk edges
`timescale 1ns/100ps
`default_nettype none
module clock_sources (
    input  wire logic [31:0] periods,
    output var  logic [3:0]  clkOut
);
    genvar g;
    for (g = 0; g < 4; g = g + 1) begin : gSrc
        initial begin
            clkOut[g] = 1'b0;
            #(1.3 + g);
            forever begin
                if (periods[8*g+:8] == 8'h00) begin
                    clkOut[g] = 1'b0;
                    #8;
                end else begin
                    #(4 * periods[8*g+:8]) clkOut[g] = ~clkOut[g];
                end
            end
        end
    end
endmodule // clock_sources
`default_nettype wire

// ---- bench/ref_select_chk.sv ----
// pin-level assertions for the reference selector
// bound to the selector top; one clock domain, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module ref_select_chk #(
    parameter [15:0] ID_VALUE  = 16'h5A31,  // arbitrary value
    parameter [7:0]  REV_VALUE = 8'h01      // arbitrary value
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       csN,
    input wire logic       rdN,
    input wire logic       wrN,
    input wire logic [4:0] addr,
    input wire logic [7:0] dataOut,
    input wire logic       dataOe,
    input wire logic       refValid,
    input wire logic       noValidInputFlag,
    input wire logic       rateSel2048,
    input wire logic       irq
);
    logic [3:0] sinceWr;
    logic       wrote;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // strobes are async and synced inside, so only a coarse window is asked for
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sinceWr <= 4'hF;
            wrote   <= 1'b0;
        end else if (!wrN) begin
            sinceWr <= 4'h0;
            wrote   <= 1'b1;
        end else if (sinceWr != 4'hF) begin
            sinceWr <= sinceWr + 4'h1;
        end
    end
    a_no_input_flag: assert property (noValidInputFlag == !refValid)
        else $error("no-input flag disagrees with reference valid");
    a_read_drive_on: assert property ((!csN && !rdN) [*5] |-> dataOe)
        else $error("read data not driven");
    a_read_drive_off: assert property ((csN || rdN) [*5] |-> !dataOe)
        else $error("read data driven outside a read");
    a_id_high_read: assert property ((!csN && !rdN && addr == 5'h00) [*5] |->
        dataOut == ID_VALUE[15:8])
        else $error("identity high byte wrong");
    a_id_low_read: assert property ((!csN && !rdN && addr == 5'h01) [*5] |->
        dataOut == ID_VALUE[7:0])
        else $error("identity low byte wrong");
    a_rev_read: assert property ((!csN && !rdN && addr == 5'h02) [*5] |->
        dataOut == REV_VALUE)
        else $error("revision wrong");
    a_rate_after_write: assert property ($changed(rateSel2048) |-> sinceWr <= 4'h8)
        else $error("rate select moved without a write");
    a_irq_needs_enable: assert property (!wrote |-> !irq)
        else $error("interrupt before any enable was written");
endmodule // ref_select_chk

bind reference_select_and_id ref_select_chk #(.ID_VALUE(ID_VALUE), .REV_VALUE(REV_VALUE)) u_chk (
    .clk(clk), .rst_n(rst_n), .csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr),
    .dataOut(dataOut), .dataOe(dataOe), .refValid(refValid),
    .noValidInputFlag(noValidInputFlag), .rateSel2048(rateSel2048), .irq(irq));
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the reference selector
// drives the processor port at falling edges and the sources by period
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk;
    logic        rst_n;
    logic        csN;
    logic        rdN;
    logic        wrN;
    logic [4:0]  addr;
    logic [7:0]  dataIn;
    logic [7:0]  dataOut;
    logic        dataOe;
    logic [1:0]  refSel;
    logic        refValid;
    logic        noValidInputFlag;
    logic        rateSel2048;
    logic        irq;
    logic [3:0]  srcClk;
    logic [31:0] srcPeriod;
    int          n_mismatch;
    int          n_checks;
    int          i;

    clock_sources i_src (.periods(srcPeriod), .clkOut(srcClk));
    reference_select_and_id #(.ID_VALUE(16'h6B27), .REV_VALUE(8'h03)) i_dut (
        .clk(clk), .rst_n(rst_n), .compositeInputOne(srcClk[0]),
        .compositeInputTwo(srcClk[1]), .cmosInputThree(srcClk[2]),
        .cmosInputFour(srcClk[3]), .csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .refSel(refSel),
        .refValid(refValid), .noValidInputFlag(noValidInputFlag),
        .rateSel2048(rateSel2048), .irq(irq));

    always #4 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    // strobes held well past the synchronizer depth
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        dataIn = d;
        csN = 1'b0;
        wrN = 1'b0;
        tick(4);
        wrN = 1'b1;
        tick(1);
        csN = 1'b1;
        tick(4);
    endtask
    task automatic rdck(input logic [4:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        csN = 1'b0;
        rdN = 1'b0;
        tick(5);
        check(dataOut, exp);
        rdN = 1'b1;
        csN = 1'b1;
        tick(4);
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic t_ident;
        rdck(5'h00, 8'h6B);
        rdck(5'h02, 8'h03);
        wr(5'h04, 8'h78);
        check({7'h00, rateSel2048}, 8'h00);
        rdck(5'h04, 8'h70);
        rdck(5'h1F, 8'h00);
        rdck(5'h0B, 8'h00);
        wr(5'h03, 8'hA5);
        rdck(5'h03, 8'hA5);
        wr(5'h00, 8'hFF);
        wr(5'h01, 8'h00);
        rdck(5'h00, 8'h6B);
        rdck(5'h01, 8'h27);
    endtask
    task automatic t_setup;
        wr(5'h04, 8'h78);
        check({7'h00, rateSel2048}, 8'h01);
        wr(5'h04, 8'h70);
        check({7'h00, rateSel2048}, 8'h00);
        // 125 cycles is 1 MHz, a multiple of 8 kHz
        for (i = 0; i < 4; i++) begin
            wr(5'(13 + 2 * i), 8'h7D);
            wr(5'(14 + 2 * i), 8'h00);
        end
        tick(1000);
        rdck(5'h09, 8'h0F);
        check({6'h00, refSel}, 8'h00);
    endtask
    task automatic t_limits;
        srcPeriod[7:0] = 8'h83;
        tick(1000);
        rdck(5'h09, 8'h1F);
        check({6'h00, refSel}, 8'h00);
        wr(5'h0A, 8'h0F);
        rdck(5'h0A, 8'h00);
        wr(5'h0B, 8'h01);
        srcPeriod[7:0] = 8'h8C;
        tick(1000);
        rdck(5'h09, 8'h1E);
        check({6'h00, refSel}, 8'h01);
        rdck(5'h0A, 8'h01);
        check({7'h00, irq}, 8'h01);
        wr(5'h0A, 8'h01);
        check({7'h00, irq}, 8'h00);
    endtask
    task automatic t_prio_force;
        wr(5'h05, 8'h01);
        check({6'h00, refSel}, 8'h02);
        wr(5'h04, 8'h77);
        check({5'h00, refValid, refSel}, 8'h07);
        wr(5'h04, 8'h71);
        check({6'h00, refValid, noValidInputFlag}, 8'h01);
        wr(5'h04, 8'h70);
        srcPeriod = 32'hC8C8C8C8;
        tick(1500);
        check({6'h00, refValid, noValidInputFlag}, 8'h01);
        rdck(5'h09, 8'hF0);
        // hard check off: the same off-frequency inputs must come back valid
        wr(5'h04, 8'h60);
        tick(500);
        check({5'h00, refValid, refSel}, 8'h04);
        rdck(5'h09, 8'hFF);
        check({7'h00, irq}, 8'h01);
    endtask

    initial begin
        #100000;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        addr = 5'h00;
        dataIn = 8'h00;
        srcPeriod = 32'h7D7D7D7D;
        n_mismatch = 0;
        n_checks = 0;
        tick(5);
        rst_n = 1'b1;
        t_ident;
        t_setup;
        t_limits;
        t_prio_force;
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire

// ---- core/clock_input_monitor.v ----
// one input clock monitor: period measure, activity and limit alarms
// assumes a raw pin input, asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "ref_select_regs.vh"

module clock_input_monitor (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clkPin,
    input  wire [15:0] nominal,
    input  wire [7:0]  hardLimit,
    input  wire [7:0]  softLimit,
    input  wire        hardEn,
    input  wire        softEn,
    input  wire        actEn,
    output wire        valid,
    output reg         softFlag
);

    function [15:0] absDiff;
        input [15:0] a;
        input [15:0] b;
        begin
            absDiff = (a > b) ? a - b : b - a;
        end
    endfunction

    reg        pinS1;
    reg        pinS2;
    reg        pinLast;
    reg [15:0] count;
    reg        hardAlarm;
    wire       rise;
    wire       noActivity;
    wire [15:0] err;

    assign rise       = pinS2 & ~pinLast;
    assign noActivity = (count == `PERIOD_MAX);
    assign err        = absDiff(count, nominal);

    // inputs above half of clk cannot be measured; they read as off-frequency
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinS1     <= 1'b0;
            pinS2     <= 1'b0;
            pinLast   <= 1'b0;
            count     <= 16'h0000;
            hardAlarm <= 1'b1;
            softFlag  <= 1'b0;
        end else begin
            pinS1   <= clkPin;
            pinS2   <= pinS1;
            pinLast <= pinS2;
            if (rise) begin
                count     <= 16'h0001;
                hardAlarm <= hardEn & (err >= {8'h00, hardLimit});
                softFlag  <= softEn & (err >= {8'h00, softLimit});
            end else if (!noActivity) begin
                count <= count + 16'h0001;
            end
        end
    end

    // activity verdict only counts while actEn is set; the frequency verdict counts as hardEn stood at the last input rise
    assign valid = ~(actEn & noActivity) & ~hardAlarm;

endmodule // clock_input_monitor

`default_nettype wire

// ---- core/ref_select_regs.vh ----
// register offsets, control field positions, reset values and the period limit
// for the reference selector; included by the selector and its monitors
//
// How it works
// - every input clock is watched for activity and frequency while its monitor is enabled.
// - an input whose period error reaches the hard limit is declared invalid.
// - an input whose error reaches only the soft limit is flagged and stays valid.
// - software gives each input a priority number, zero meaning unavailable.
// - outside forcing, the valid input with the best priority becomes the reference.
// - software can force one named input to be the reference.
// - any input that is a multiple of 8 kHz up to 62.5 MHz is accepted via its nominal period.
// - a control bit selects 1544 kHz or 2048 kHz for the multiplied clock output.
// - a fixed 16-bit identity value is read from two byte registers and ignores writes.
// - a revision register reports the silicon revision.
// - unless the write guard holds its key, writes to all other registers are dropped.
// - outside forcing, an invalid input is never selected, and with none valid the no-input flag is set.
// - each validity change sets a latched bit that raises the interrupt when enabled.
`ifndef REF_SELECT_REGS_VH
`define REF_SELECT_REGS_VH

`define ADDR_ID_HIGH    5'h00
`define ADDR_ID_LOW     5'h01
`define ADDR_REVISION   5'h02
`define ADDR_GUARD      5'h03
`define ADDR_CONTROL    5'h04
`define ADDR_PRIO_LOW   5'h05
`define ADDR_PRIO_HIGH  5'h06
`define ADDR_HARD_LIMIT 5'h07
`define ADDR_SOFT_LIMIT 5'h08
`define ADDR_VALID      5'h09
`define ADDR_CHANGED    5'h0A
`define ADDR_IRQ_EN     5'h0B
`define ADDR_SELECTION  5'h0C
`define ADDR_NOMINAL0   5'h0D

`define CTRL_FORCE_EN   0
`define CTRL_FORCE_LSB  1
`define CTRL_RATE_2048  3
`define CTRL_HARD_EN    4
`define CTRL_SOFT_EN    5
`define CTRL_ACT_EN     6

`define GUARD_KEY       8'hA5
`define RESET_GUARD     8'h00
`define RESET_CONTROL   8'h70
`define RESET_PRIO_LOW  8'h21
`define RESET_PRIO_HIGH 8'h43
`define RESET_HARD_LIM  8'h08
`define RESET_SOFT_LIM  8'h04
`define RESET_NOMINAL   16'h3D09

`define PERIOD_MAX      16'hFFFF

`endif

// ---- core/reference_select_and_id.v ----
// reference selector with identity, revision and write guard registers
// assumes an 8-bit asynchronous processor port and four raw clock pins
`timescale 1ns/100ps
`default_nettype none
`include "ref_select_regs.vh"

module reference_select_and_id #(
    parameter [15:0] ID_VALUE  = 16'h5A31,  // arbitrary value
    parameter [7:0]  REV_VALUE = 8'h01      // arbitrary value
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       compositeInputOne,
    input  wire       compositeInputTwo,
    input  wire       cmosInputThree,
    input  wire       cmosInputFour,
    input  wire       csN,
    input  wire       rdN,
    input  wire       wrN,
    input  wire [4:0] addr,
    input  wire [7:0] dataIn,
    output reg  [7:0] dataOut,
    output reg        dataOe,
    output reg  [1:0] refSel,
    output reg        refValid,
    output reg        noValidInputFlag,
    output wire       rateSel2048,
    output wire       irq
);

    function [3:0] prioOf;
        input [15:0] prios;
        input [1:0]  idx;
        begin
            prioOf = prios[idx*4 +: 4];
        end
    endfunction

    // port synchronisers
    reg        csS1;
    reg        csS2;
    reg        rdS1;
    reg        rdS2;
    reg        wrS1;
    reg        wrS2;
    reg [4:0]  addrS1;
    reg [4:0]  addrS2;
    reg [7:0]  dataS1;
    reg [7:0]  dataS2;
    reg        wrLast;
    reg        csLast;

    // software registers
    reg [7:0]  guard;
    reg [7:0]  control;
    reg [15:0] prios;
    reg [7:0]  hardLimit;
    reg [7:0]  softLimit;
    reg [3:0]  changed;
    reg [3:0]  irqEn;
    reg [63:0] nominals;

    // monitor state
    wire [3:0] valid;
    wire [3:0] softFlag;
    reg  [3:0] validLast;
    wire [3:0] pins;

    // selection
    reg  [1:0] next_refSel;
    reg        next_refValid;
    reg  [3:0] bestPrio;
    reg  [7:0] next_dataOut;
    integer    i;
    integer    j;

    wire       wrCommit;
    wire       unlocked;
    wire       wrAllowed;
    wire [1:0] forceSel;
    wire [4:0] nomOff;

    assign pins = {cmosInputFour, cmosInputThree,
                   compositeInputTwo, compositeInputOne};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : mon
            clock_input_monitor u_mon (
                .clk       (clk),
                .rst_n     (rst_n),
                .clkPin    (pins[g]),
                .nominal   (nominals[g*16 +: 16]),
                .hardLimit (hardLimit),
                .softLimit (softLimit),
                .hardEn    (control[`CTRL_HARD_EN]),
                .softEn    (control[`CTRL_SOFT_EN]),
                .actEn     (control[`CTRL_ACT_EN]),
                .valid     (valid[g]),
                .softFlag  (softFlag[g])
            );
        end
    endgenerate

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csS1   <= 1'b1;
            csS2   <= 1'b1;
            rdS1   <= 1'b1;
            rdS2   <= 1'b1;
            wrS1   <= 1'b1;
            wrS2   <= 1'b1;
            addrS1 <= 5'h00;
            addrS2 <= 5'h00;
            dataS1 <= 8'h00;
            dataS2 <= 8'h00;
            wrLast <= 1'b1;
            csLast <= 1'b1;
        end else begin
            csS1   <= csN;
            csS2   <= csS1;
            rdS1   <= rdN;
            rdS2   <= rdS1;
            wrS1   <= wrN;
            wrS2   <= wrS1;
            addrS1 <= addr;
            addrS2 <= addrS1;
            dataS1 <= dataIn;
            dataS2 <= dataS1;
            wrLast <= wrS2;
            csLast <= csS2;
        end
    end

    // a write lands on the rising edge of the write strobe, so
    // address and data must stay steady until the rise of the strobe is sampled
    assign wrCommit  = wrS2 & ~wrLast & ~csLast;
    assign unlocked  = (guard == `GUARD_KEY);
    assign wrAllowed = wrCommit & unlocked;
    assign forceSel  = control[`CTRL_FORCE_LSB +: 2];
    assign nomOff    = addrS2 - `ADDR_NOMINAL0;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            guard <= `RESET_GUARD;
        end else if (wrCommit && addrS2 == `ADDR_GUARD) begin
            guard <= dataS2;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control   <= `RESET_CONTROL;
            prios     <= {`RESET_PRIO_HIGH, `RESET_PRIO_LOW};
            hardLimit <= `RESET_HARD_LIM;
            softLimit <= `RESET_SOFT_LIM;
            irqEn     <= 4'h0;
            nominals  <= {4{`RESET_NOMINAL}};
        end else if (wrAllowed) begin
            case (addrS2)
                `ADDR_CONTROL: begin
                    control <= dataS2;
                end
                `ADDR_PRIO_LOW: begin
                    prios[7:0] <= dataS2;
                end
                `ADDR_PRIO_HIGH: begin
                    prios[15:8] <= dataS2;
                end
                `ADDR_HARD_LIMIT: begin
                    hardLimit <= dataS2;
                end
                `ADDR_SOFT_LIMIT: begin
                    softLimit <= dataS2;
                end
                `ADDR_IRQ_EN: begin
                    irqEn <= dataS2[3:0];
                end
                default: begin
                    if (nomOff < 5'h08) begin
                        nominals[nomOff*8 +: 8] <= dataS2;
                    end
                end
            endcase
        end
    end

    // latched validity change, write one to clear; a new change wins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            validLast <= 4'h0;
            changed   <= 4'h0;
        end else begin
            validLast <= valid;
            for (j = 0; j < 4; j = j + 1) begin
                if (valid[j] != validLast[j]) begin
                    changed[j] <= 1'b1;
                end else if (wrAllowed && addrS2 == `ADDR_CHANGED && dataS2[j]) begin
                    changed[j] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(changed & irqEn);
    assign rateSel2048 = control[`CTRL_RATE_2048];

    // evaluated every cycle, so outside forcing a failed reference is replaced next cycle
    always @* begin
        next_refSel   = 2'b00;
        next_refValid = 1'b0;
        bestPrio      = 4'hF;
        if (control[`CTRL_FORCE_EN]) begin
            next_refSel   = forceSel;
            next_refValid = valid[forceSel];
        end else begin
            for (i = 3; i >= 0; i = i - 1) begin
                if (valid[i] && prioOf(prios, i[1:0]) != 4'h0 &&
                    prioOf(prios, i[1:0]) <= bestPrio) begin
                    bestPrio      = prioOf(prios, i[1:0]);
                    next_refSel   = i[1:0];
                    next_refValid = 1'b1;
                end
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refSel           <= 2'b00;
            refValid         <= 1'b0;
            noValidInputFlag <= 1'b1;
        end else begin
            refSel           <= next_refSel;
            refValid         <= next_refValid;
            noValidInputFlag <= ~next_refValid;
        end
    end

    always @* begin
        next_dataOut = 8'h00;
        case (addrS2)
            `ADDR_ID_HIGH: begin
                next_dataOut = ID_VALUE[15:8];
            end
            `ADDR_ID_LOW: begin
                next_dataOut = ID_VALUE[7:0];
            end
            `ADDR_REVISION: begin
                next_dataOut = REV_VALUE;
            end
            `ADDR_GUARD: begin
                next_dataOut = guard;
            end
            `ADDR_CONTROL: begin
                next_dataOut = control;
            end
            `ADDR_PRIO_LOW: begin
                next_dataOut = prios[7:0];
            end
            `ADDR_PRIO_HIGH: begin
                next_dataOut = prios[15:8];
            end
            `ADDR_HARD_LIMIT: begin
                next_dataOut = hardLimit;
            end
            `ADDR_SOFT_LIMIT: begin
                next_dataOut = softLimit;
            end
            `ADDR_VALID: begin
                next_dataOut = {softFlag, valid};
            end
            `ADDR_CHANGED: begin
                next_dataOut = {4'h0, changed};
            end
            `ADDR_IRQ_EN: begin
                next_dataOut = {4'h0, irqEn};
            end
            `ADDR_SELECTION: begin
                next_dataOut = {4'h0, noValidInputFlag, refValid, refSel};
            end
            default: begin
                if (nomOff < 5'h08) begin
                    next_dataOut = nominals[nomOff*8 +: 8];
                end
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOut <= 8'h00;
            dataOe  <= 1'b0;
        end else begin
            dataOut <= next_dataOut;
            dataOe  <= ~csS2 & ~rdS2;
        end
    end

endmodule // reference_select_and_id

`default_nettype wire
